// >>> core/srt_top.v
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "srt_consts.vh"
module srt_top #(
  parameter [`SRT_CNT_W-1:0] IMP_SHORT_CYC = `SRT_IMP_SHORT_CYC,
  parameter [`SRT_CNT_W-1:0] IMP_LONG_CYC = `SRT_IMP_LONG_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [7:0] src_patched_i,
  input wire [7:0] src_key1_i,
  input wire [7:0] src_key2_i,
  input wire [7:0] src_sel_i,
  input wire [7:0] src_on_i,
  input wire [7:0] src_fader_i,
  input wire [7:0] src_ch_master_i,
  input wire [7:0] src_ch_group_i,
  input wire [7:0] src_grp_master_i,
  input wire [7:0] src_m_sel_i,
  input wire [7:0] src_m_fader_i,
  input wire [7:0] src_m_on_i,
  input wire [31:0] sys_relay_i,
  output reg [31:0] relay_o,
  output reg [3:0] studio_lamp_o
);
  reg ctrl_en;
  reg [31:0] rsv_mask;
  reg [`SRT_SL_W-1:0] slot_cfg [0:`SRT_NSLOTS-1];
  reg [`SRT_RC_W-1:0] rel_cfg [0:`SRT_NREL-1];
  reg [`SRT_NREL-1:0] relay_trig;
  reg [`SRT_NREL-1:0] next_relay;
  reg [3:0] next_lamp;
  reg [31:0] next_rdata;
  reg [31:0] wmask;
  integer k;
  integer r;
  integer c;

  wire [`SRT_NSLOTS-1:0] slot_act;
  wire [`SRT_NREL-1:0] contact;
  wire req;
  wire wr;
  wire [3:0] region;
  wire [4:0] idx;
  wire in_slot;
  wire in_rcfg;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign region = wb_adr_i[11:8];
  assign idx = wb_adr_i[6:2];
  assign in_slot = (region == `SRT_SLOT_REGION) && (wb_adr_i[7] == 1'b0);
  assign in_rcfg = (region == `SRT_RCFG_REGION) && (wb_adr_i[7] == 1'b0);

  always @* begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  // bus slave: one wait state, ack drops after one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? next_rdata : 32'h00000000;
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    if (in_slot) begin
      next_rdata[`SRT_SL_W-1:0] = slot_cfg[idx];
    end else if (in_rcfg) begin
      next_rdata[`SRT_RC_W-1:0] = rel_cfg[idx];
    end else begin
      case (wb_adr_i)
        `SRT_CTRL_OFS: next_rdata[`SRT_CTRL_EN] = ctrl_en;
        `SRT_STAT_OFS: next_rdata = relay_o;
        `SRT_RSV_OFS: next_rdata = rsv_mask;
        `SRT_LAMP_OFS: next_rdata[3:0] = studio_lamp_o;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // configuration storage, live writable
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_en <= `SRT_CTRL_RST;
      rsv_mask <= `SRT_RSV_RST;
      for (c = 0; c < `SRT_NSLOTS; c = c + 1) begin
        slot_cfg[c] <= `SRT_SL_RST;
        rel_cfg[c] <= `SRT_RC_RST;
      end
    end else if (wr) begin
      if (in_slot) begin
        slot_cfg[idx] <= (slot_cfg[idx] & ~wmask[`SRT_SL_W-1:0]) // RL20
          | (wb_dat_i[`SRT_SL_W-1:0] & wmask[`SRT_SL_W-1:0]);
      end else if (in_rcfg) begin
        rel_cfg[idx] <= (rel_cfg[idx] & ~wmask[`SRT_RC_W-1:0]) // RL20
          | (wb_dat_i[`SRT_RC_W-1:0] & wmask[`SRT_RC_W-1:0]);
      end else if (wb_adr_i == `SRT_CTRL_OFS && wb_sel_i[0]) begin
        ctrl_en <= wb_dat_i[`SRT_CTRL_EN];
      end else if (wb_adr_i == `SRT_RSV_OFS) begin
        rsv_mask <= (rsv_mask & ~wmask) | (wb_dat_i & wmask);
      end
    end
  end

  // per slot trigger evaluation, slot k belongs to source k/4
  genvar g;
  generate
    for (g = 0; g < `SRT_NSLOTS; g = g + 1) begin : g_slot
      srt_slot_eval u_eval ( // RL3
        .valid_i(slot_cfg[g][`SRT_SL_VALID]),
        .preset_i(slot_cfg[g][`SRT_SL_PRESET]),
        .red_i(slot_cfg[g][`SRT_SL_RED]),
        .trig_en_i(slot_cfg[g][`SRT_SL_TRIG_HI:`SRT_SL_TRIG_LO]),
        .patched_i(src_patched_i[g/`SRT_NSLOT]),
        .key1_i(src_key1_i[g/`SRT_NSLOT]),
        .key2_i(src_key2_i[g/`SRT_NSLOT]),
        .sel_i(src_sel_i[g/`SRT_NSLOT]),
        .on_i(src_on_i[g/`SRT_NSLOT]),
        .fader_i(src_fader_i[g/`SRT_NSLOT]),
        .ch_master_i(src_ch_master_i[g/`SRT_NSLOT]),
        .ch_group_i(src_ch_group_i[g/`SRT_NSLOT]),
        .grp_master_i(src_grp_master_i[g/`SRT_NSLOT]),
        .m_sel_i(src_m_sel_i[g/`SRT_NSLOT]),
        .m_fader_i(src_m_fader_i[g/`SRT_NSLOT]),
        .m_on_i(src_m_on_i[g/`SRT_NSLOT]),
        .act_o(slot_act[g])
      );
    end
  endgenerate

  // OR of all slots bound to a relay; reserved relays excluded
  always @* begin
    relay_trig = {`SRT_NREL{1'b0}};
    for (k = 0; k < `SRT_NSLOTS; k = k + 1) begin
      if (slot_act[k]) begin
        relay_trig[slot_cfg[k][`SRT_SL_REL_HI:`SRT_SL_REL_LO]] = 1'b1; // RL7 RL14 RL16
      end
    end
    relay_trig = relay_trig & ~rsv_mask & {`SRT_NREL{ctrl_en}}; // RL2
  end

  // one driver per relay, 16 per card
  generate
    for (g = 0; g < `SRT_NREL; g = g + 1) begin : g_rel
      srt_relay_drv #(
        .SHORT_CYC(IMP_SHORT_CYC),
        .LONG_CYC(IMP_LONG_CYC)
      ) u_drv ( // RL1
        .clk_i(clk_i),
        .rst_i(rst_i),
        .trig_i(relay_trig[g]),
        .impulse_i(rel_cfg[g][`SRT_RC_IMP]), // RL4 RL15
        .long_i(rel_cfg[g][`SRT_RC_LONG]), // RL6
        .contact_o(contact[g])
      );
    end
  endgenerate

  always @* begin
    next_relay = (contact & ~rsv_mask) | (sys_relay_i & rsv_mask); // RL2
    next_lamp = 4'h0;
    for (r = 0; r < `SRT_NREL; r = r + 1) begin
      if (rel_cfg[r][`SRT_RC_ASSOC] && contact[r] && !rsv_mask[r]) begin
        next_lamp[rel_cfg[r][`SRT_RC_STU_HI:`SRT_RC_STU_LO]] = 1'b1; // RL17
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      relay_o <= 32'h00000000;
      studio_lamp_o <= 4'h0;
    end else begin
      relay_o <= next_relay;
      studio_lamp_o <= next_lamp;
    end
  end
endmodule

// >>> core/srt_consts.vh
// Operation
// RL1: each relay card offers sixteen relays, named by card and relay number.
// RL2: relays reserved for system functions cannot be driven by signaling sources.
// RL3: each source has four output slots 0..3, each bound to one relay.
// RL4: each relay selects latching or impulse operation.
// RL5: latching relay stays closed exactly while its trigger holds.
// RL6: impulse relay closes for 100 ms or 200 ms, then reopens.
// RL7: several sources on one signaling relay are combined by OR.
// RL8: enabled triggers are ANDed, and the source must be patched.
// RL9: five triggers selectable: key one, key two, selector, channel on, fader.
// RL10: fader start preset forces selector, channel on and fader open.
// RL11: red light needs patched, selected, open, on input channel routed to master.
// RL12: red light also needs master selecting that path, fader open, on.
// RL13: input routed only to a group needs the group routed to master.
// RL14: several sources on one red-light relay are combined by OR.
// RL15: red-light relays also run latching or impulse, 100 or 200 ms.
// RL16: red-light relays per studio are configured independently.
// RL17: a studio-associated red-light relay also lights that studio's lamp.
// RL18: configure stereo left and right parts onto the same relay.
// RL19: impulse starts on rising trigger edge, no retrigger until released.
// RL20: configuration is writable while running and acts on next evaluation.
`ifndef SRT_CONSTS_VH
`define SRT_CONSTS_VH

`define SRT_NSRC 8
`define SRT_NSLOT 4
`define SRT_NSLOTS 32
`define SRT_RPC 16
`define SRT_NCARD 2
`define SRT_NREL 32
`define SRT_NSTUDIO 4

`define SRT_CTRL_OFS 12'h000
`define SRT_STAT_OFS 12'h004
`define SRT_RSV_OFS 12'h008
`define SRT_LAMP_OFS 12'h00C
`define SRT_SLOT_REGION 4'h1
`define SRT_RCFG_REGION 4'h2

`define SRT_CTRL_EN 0
`define SRT_CTRL_RST 1'b0
`define SRT_RSV_RST 32'h00000000

`define SRT_SL_VALID 0
`define SRT_SL_REL_LO 1
`define SRT_SL_REL_HI 5
`define SRT_SL_TRIG_LO 6
`define SRT_SL_TRIG_HI 10
`define SRT_SL_PRESET 11
`define SRT_SL_RED 12
`define SRT_SL_W 13
`define SRT_SL_RST 13'h0000

`define SRT_TRG_KEY1 0
`define SRT_TRG_KEY2 1
`define SRT_TRG_SEL 2
`define SRT_TRG_ON 3
`define SRT_TRG_FADER 4

`define SRT_RC_IMP 0
`define SRT_RC_LONG 1
`define SRT_RC_STU_LO 2
`define SRT_RC_STU_HI 3
`define SRT_RC_ASSOC 4
`define SRT_RC_W 5
`define SRT_RC_RST 5'h00

`define SRT_CLK_KHZ 250000
`define SRT_IMP_SHORT_MS 100
`define SRT_IMP_LONG_MS 200
`define SRT_CNT_W 26
`define SRT_IMP_SHORT_CYC 26'h17D7840
`define SRT_IMP_LONG_CYC 26'h2FAF080

`endif

// >>> core/srt_slot_eval.v
`timescale 1ns/1ps
`include "srt_consts.vh"
module srt_slot_eval (
  input wire valid_i,
  input wire preset_i,
  input wire red_i,
  input wire [4:0] trig_en_i,
  input wire patched_i,
  input wire key1_i,
  input wire key2_i,
  input wire sel_i,
  input wire on_i,
  input wire fader_i,
  input wire ch_master_i,
  input wire ch_group_i,
  input wire grp_master_i,
  input wire m_sel_i,
  input wire m_fader_i,
  input wire m_on_i,
  output wire act_o
);
  wire [4:0] en;
  wire [4:0] st;
  wire sig_ok;
  wire path_master;
  wire red_ok;

  assign en = trig_en_i | (preset_i ? 5'h1C : 5'h00); // RL10
  assign st = {fader_i, on_i, sel_i, key2_i, key1_i}; // RL9
  assign sig_ok = patched_i & (&(st | ~en)); // RL8
  assign path_master = ch_master_i | (ch_group_i & grp_master_i); // RL13
  assign red_ok = patched_i & sel_i & fader_i & on_i & path_master // RL11
    & m_sel_i & m_fader_i & m_on_i; // RL12
  assign act_o = valid_i & (red_i ? red_ok : sig_ok);
endmodule

// >>> core/srt_relay_drv.v
`timescale 1ns/1ps
`include "srt_consts.vh"
module srt_relay_drv #(
  parameter [`SRT_CNT_W-1:0] SHORT_CYC = `SRT_IMP_SHORT_CYC,
  parameter [`SRT_CNT_W-1:0] LONG_CYC = `SRT_IMP_LONG_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire trig_i,
  input wire impulse_i,
  input wire long_i,
  output reg contact_o
);
  reg trig_q;
  reg busy;
  reg long_q;
  reg [`SRT_CNT_W-1:0] cnt;
  wire [`SRT_CNT_W-1:0] last;

  assign last = (long_q ? LONG_CYC : SHORT_CYC) - 26'h0000001;

  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_q <= 1'b0;
      busy <= 1'b0;
      long_q <= 1'b0;
      cnt <= 26'h0000000;
      contact_o <= 1'b0;
    end else begin
      trig_q <= trig_i;
      if (!impulse_i) begin
        busy <= 1'b0;
        contact_o <= trig_i; // RL5
      end else if (busy) begin
        if (cnt == last) begin
          busy <= 1'b0;
          contact_o <= 1'b0; // RL6
        end else begin
          cnt <= cnt + 26'h0000001;
        end
      end else if (trig_i && !trig_q) begin
        busy <= 1'b1; // RL19
        long_q <= long_i;
        cnt <= 26'h0000000;
        contact_o <= 1'b1;
      end else begin
        contact_o <= 1'b0;
      end
    end
  end
endmodule

// >>> sim/srt_chk_asserts.sv
`timescale 1ns/1ps
module srt_chk_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] src_patched_i,
  input wire logic [31:0] sys_relay_i,
  input wire logic [31:0] relay_o,
  input wire logic [3:0] studio_lamp_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_reply_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 12'hFFC |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_clear_a: assert property ($fell(rst_i) |-> relay_o == 32'h0 && studio_lamp_o == 4'h0)
    else $error("outputs not cleared by reset");
  relay_cause_a: assert property ((relay_o & ~$past(relay_o)) != 32'h0 |->
    $past(src_patched_i, 2) != 8'h0 || $past(sys_relay_i) != 32'h0 || $past(sys_relay_i, 2) != 32'h0)
    else $error("relay closed without patched source");
  lamp_relay_a: assert property (studio_lamp_o != 4'h0 |-> relay_o != 32'h0)
    else $error("lamp lit with no relay closed");
endmodule

// >>> sim/srt_equip.sv
`timescale 1ns/1ps
module srt_equip #(
  parameter int IDX = 3
) (
  input wire logic clk_i,
  input wire logic [31:0] relay_i,
  output logic [31:0] close_len_o
);
  logic [31:0] n = 32'h0;
  initial close_len_o = 32'h0;
  // transport start input: measures each contact closure
  always @(posedge clk_i) begin
    if (relay_i[IDX]) begin
      n <= n + 32'h1;
    end else begin
      if (n != 32'h0) close_len_o <= n;
      n <= 32'h0;
    end
  end
endmodule

// >>> sim/srt_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack;
  logic [11:0] adr;
  logic [31:0] dat, sys, rd, rdat, relay, clen;
  logic [3:0] lamp, sel;
  logic [7:0] s [12];
  logic [4:0] en0, en1;
  int errors = 0;
  int samples_checked = 0;
  int cyc_n = 0;
  srt_top #(.IMP_SHORT_CYC(26'h00000A), .IMP_LONG_CYC(26'h000014)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .src_patched_i(s[0]), .src_key1_i(s[1]), .src_key2_i(s[2]),
    .src_sel_i(s[3]), .src_on_i(s[4]), .src_fader_i(s[5]), .src_ch_master_i(s[6]), .src_ch_group_i(s[7]),
    .src_grp_master_i(s[8]), .src_m_sel_i(s[9]), .src_m_fader_i(s[10]), .src_m_on_i(s[11]),
    .sys_relay_i(sys), .relay_o(relay), .studio_lamp_o(lamp));
  srt_equip #(.IDX(3)) eq_u (.clk_i(clk_i), .relay_i(relay), .close_len_o(clen));
  function automatic logic ev(int n, logic [4:0] en, logic red);
    if (red) return s[0][n] & s[3][n] & s[4][n] & s[5][n] & (s[6][n] | s[7][n] & s[8][n]) & s[9][n] & s[10][n] & s[11][n];
    return s[0][n] & (&(~en | {s[5][n], s[4][n], s[3][n], s[2][n], s[1][n]}));
  endfunction
  task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    if (n >= 50) errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask
  task automatic chkrd(input logic [11:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    `CHK("read", e, rd)
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic conclude();
    $display("counts errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    {rst_i, cyc, stb, we, sel, adr, dat, sys} = {8'h80, 12'h0, 64'h0};
    foreach (s[i]) s[i] = 8'h00;
    void'($urandom(74146));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    chkrd(12'h100, 32'h0);
    chkrd(12'h200, 32'h0);
    wr(12'hFFC, 32'hFFFFFFFF);
    chkrd(12'hFFC, 32'h0);
    wr(12'h000, 32'h1);
    wr(12'h130, 32'h80F);
    wr(12'h120, 32'h102B);
    wr(12'h150, 32'h102B);
    wr(12'h254, 32'h18);
    $display("test bus done");
    for (int i = 0; i < 40; i++) begin
      en0 = i == 0 ? 5'h00 : i == 1 ? 5'h1F : 5'($urandom);
      en1 = 5'($urandom);
      wr(12'h100, {21'h0, en0, 5'h03, 1'h1});
      wr(12'h110, {21'h0, en1, 5'h03, 1'h1});
      foreach (s[j]) s[j] <= i == 39 ? 8'hBF : 8'($urandom | $urandom);
      settle();
      `CHK("relay3", ev(0, en0, 1'b0) | ev(1, en1, 1'b0), relay[3])
      `CHK("relay7", ev(3, 5'h1C, 1'b0), relay[7])
      `CHK("relay21", ev(2, 5'h00, 1'b1) | ev(5, 5'h00, 1'b1), relay[21])
      `CHK("lamp2", ev(2, 5'h00, 1'b1) | ev(5, 5'h00, 1'b1), lamp[2])
    end
    @(posedge clk_i) s[6] <= 8'h00;
    settle();
    `CHK("grouped", 1'b1, relay[21])
    chkrd(12'h00C, 32'h4);
    @(posedge clk_i) s[8] <= 8'h00;
    settle();
    `CHK("group", 1'b0, relay[21])
    $display("test trig done");
    @(posedge clk_i) foreach (s[j]) s[j] <= 8'h00;
    wr(12'h100, 32'h7);
    for (int k = 0; k < 2; k++) begin
      wr(12'h20C, k ? 32'h3 : 32'h1);
      s[0] <= 8'h01;
      repeat (40) @(posedge clk_i);
      #1;
      `CHK("pulse", k ? 32'h14 : 32'h0A, clen)
      `CHK("held", 1'b0, relay[3])
      @(posedge clk_i) s[0] <= 8'h00;
      settle();
    end
    $display("test impulse done");
    wr(12'h20C, 32'h0);
    wr(12'h008, 32'h8);
    chkrd(12'h008, 32'h8);
    s[0] <= 8'h01;
    settle();
    `CHK("reserved", 1'b0, relay[3])
    @(posedge clk_i) sys <= 32'h8;
    settle();
    `CHK("sysdrv", 1'b1, relay[3])
    chkrd(12'h004, 32'h8);
    @(posedge clk_i) sys <= 32'h0;
    wr(12'h008, 32'h0);
    settle();
    `CHK("latch", 1'b1, relay[3])
    wr(12'h000, 32'h0);
    settle();
    `CHK("disabled", 32'h0, relay)
    $display("test reserve done");
    conclude();
  end
endmodule
bind srt_top srt_chk_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_patched_i(src_patched_i),
  .sys_relay_i(sys_relay_i), .relay_o(relay_o), .studio_lamp_o(studio_lamp_o));
